/* File: sdr_pkg.sv */
package sdr_pkg;
  localparam int WORD_BITS     = 24;
  localparam int CLK_HZ        = 25000000;
  localparam int XTAL_HZ       = 32768;
  // crystal periods per result: 69 x 8 x 3
  localparam int CONV_TICKS    = 69 * 8 * 3;
  localparam int LOCK_TICKS    = 64;
  localparam int SCLK_HALF_NS  = 160;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int GAIN_SHIFT    = 4;
  localparam int XFER_W        = 16;

  localparam logic [3:0] ADR_AIN    = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_RESULT = 4'h8;
  localparam logic [3:0] ADR_XFERS  = 4'hc;

  localparam int ST_SEL   = 0;
  localparam int ST_LOCK  = 1;
  localparam int ST_RDY   = 2;
  localparam int ST_MODE  = 3;
  localparam int ST_RANGE = 4;
  localparam int ST_ROUTE = 5;
  localparam int ST_BUSY  = 6;

  // synchroniser lanes
  localparam int PIN_CS    = 0;
  localparam int PIN_MODE  = 1;
  localparam int PIN_RANGE = 2;
  localparam int PIN_ROUTE = 3;
  localparam int PIN_SCLK  = 4;
  localparam int PIN_XTAL  = 5;
  localparam int PIN_NUM   = 6;
  localparam logic [PIN_NUM-1:0] PIN_RST = 6'h3f;

  typedef enum logic [2:0] {
    S_OFF, S_LOCK, S_CONV, S_UPD, S_READY, S_SHIFT, S_TAIL
  } sdr_state_t;
endpackage

/* File: sdr_sync.sv */
`timescale 1ns/1ps
module sdr_sync
  import sdr_pkg::*;
#(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sdr_sync_t;

  sdr_sync_t q;
  sdr_sync_t d;

  if (WIDTH < 1) begin : g_bad
    $error("sync width must be positive");
  end

  always_comb begin
    d.meta   = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule

/* File: sdr_conv.sv */
`timescale 1ns/1ps
module sdr_conv
  import sdr_pkg::*;
#(
  parameter int W     = WORD_BITS,
  parameter int TICKS = CONV_TICKS
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic         xtal_tick,
  input  wire logic [W-1:0] ain,
  input  wire logic         gain16,
  output logic              done,
  output logic      [W-1:0] code
);
  localparam int CW = $clog2(TICKS);
  localparam int EW = W + GAIN_SHIFT + 1;
  localparam logic [W-1:0] MID = {1'b1, {(W-1){1'b0}}};

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
    logic [W-1:0]  code;
  } sdr_conv_t;

  sdr_conv_t q;
  sdr_conv_t d;

  if (W < 8 || W > 32 || TICKS < 2) begin : g_bad
    $error("converter parameters out of range");
  end

  // offset binary, gain applied, saturated at both ends
  function automatic logic [W-1:0] to_code(input logic [W-1:0] a,
                                           input logic g16);
    logic signed [EW-1:0] v;
    v = signed'({{(EW-W){a[W-1]}}, a});
    if (g16) begin
      v = v <<< GAIN_SHIFT;
    end
    v = v + signed'({{(EW-W){1'b0}}, MID});
    if (v < 0) begin
      to_code = '0;
    end else if (v[EW-2:W] != '0) begin
      to_code = '1;
    end else begin
      to_code = v[W-1:0];
    end
  endfunction

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!run) begin
      d.cnt = '0;
    end else if (xtal_tick) begin
      if (q.cnt == CW'(TICKS - 1)) begin
        d.cnt  = '0;
        d.done = 1'b1;
        d.code = to_code(ain, gain16);
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign code = q.code;

  zero_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q.done && $past(ain) == '0 |-> q.code == MID)
    else $error("zero input does not give mid code");
endmodule

/* File: sdr_top.sv */
`timescale 1ns/1ps
module sdr_top
  import sdr_pkg::*;
#(
  parameter int WORD_P      = WORD_BITS,
  parameter int CONV_P      = CONV_TICKS,
  parameter int LOCK_P      = LOCK_TICKS,
  parameter int SCLK_HALF_P = SCLK_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [3:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        cs_n,
  input  wire logic        mode_sel,
  input  wire logic        range_sel,
  input  wire logic        excitation_route_select,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  output logic             dout_rdy,
  output logic             dout_oe_n,
  input  wire logic        crystal_in,
  output logic             crystal_out,
  output logic             excitation_out_a,
  output logic             excitation_out_b
);
  localparam int LW = $clog2(LOCK_P + 1);
  localparam int BW = $clog2(WORD_P + 1);
  localparam int DW = $clog2(SCLK_HALF_P + 1);
  localparam logic [DW-1:0] DIV_MAX = DW'(SCLK_HALF_P - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_P - 1);
  localparam int TAIL_MAX = SCLK_HALF_P + 1;

  if (WORD_P < 8 || WORD_P > 32 || LOCK_P < 1 || SCLK_HALF_P < 1)
  begin : g_bad
    $error("top parameters out of range");
  end

  typedef struct packed {
    sdr_state_t          state;
    logic [LW-1:0]       lock_cnt;
    logic [BW-1:0]       bit_cnt;
    logic [DW-1:0]       div_cnt;
    logic                sclk;
    logic                dout;
    logic                sclk_oe_n;
    logic                dout_oe_n;
    logic [WORD_P-1:0]   shreg;
    logic [WORD_P-1:0]   result;
    logic [WORD_P-1:0]   ain;
    logic [XFER_W-1:0]   xfers;
    logic                exc_a;
    logic                exc_b;
    logic                xtal_out;
    logic                xtal_prev;
    logic                sclk_prev;
    logic                ack;
    logic [31:0]         rdata;
  } sdr_top_t;

  sdr_top_t q;
  sdr_top_t d;

  logic [PIN_NUM-1:0] pins_s;
  logic               cs_s;
  logic               mode_s;
  logic               xtal_tick;
  logic               conv_run;
  logic               conv_done;
  logic [WORD_P-1:0]  conv_code;
  logic               m_tog;
  logic               fall_ev;
  logic               rise_ev;

  ////////////////////////////////////////////////////////////////////////
  sdr_sync #(
    .WIDTH   (PIN_NUM),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({crystal_in, sclk_in, excitation_route_select,
                range_sel, mode_sel, cs_n}),
    .sync_out (pins_s)
  );

  assign cs_s      = pins_s[PIN_CS];
  assign mode_s    = pins_s[PIN_MODE];
  assign xtal_tick = pins_s[PIN_XTAL] & ~q.xtal_prev;
  assign conv_run  = q.state != S_OFF && q.state != S_LOCK;

  sdr_conv #(
    .W     (WORD_P),
    .TICKS (CONV_P)
  ) u_conv (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (conv_run),
    .xtal_tick (xtal_tick),
    .ain       (q.ain),
    .gain16    (~pins_s[PIN_RANGE]),
    .done      (conv_done),
    .code      (conv_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // sclk edges: own divider when master, synced pin when slave
  assign m_tog = !mode_s && (q.state == S_READY || q.state == S_SHIFT)
                 && q.div_cnt == DIV_MAX;
  always_comb begin
    if (!mode_s) begin
      fall_ev = m_tog && q.sclk;
      rise_ev = m_tog && !q.sclk;
    end else begin
      // slave line parks high, so a fall starts each group
      fall_ev = q.sclk_prev && !pins_s[PIN_SCLK];
      rise_ev = !q.sclk_prev && pins_s[PIN_SCLK];
    end
  end

  function automatic logic [31:0] reg_read(input sdr_top_t s,
                                           input logic [3:0] a,
                                           input logic [PIN_NUM-1:0] p);
    logic [31:0] w;
    w = '0;
    case (a)
      ADR_AIN:    w[WORD_P-1:0] = s.ain;
      ADR_RESULT: w[WORD_P-1:0] = s.result;
      ADR_XFERS:  w[XFER_W-1:0] = s.xfers;
      ADR_STATUS: begin
        w[ST_SEL]   = s.state != S_OFF;
        w[ST_LOCK]  = s.state != S_OFF && s.state != S_LOCK;
        w[ST_RDY]   = s.state == S_READY;
        w[ST_MODE]  = p[PIN_MODE];
        w[ST_RANGE] = p[PIN_RANGE];
        w[ST_ROUTE] = p[PIN_ROUTE];
        w[ST_BUSY]  = s.state == S_SHIFT || s.state == S_TAIL;
      end
      default:    w = '0;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.ack       = 1'b0;
    d.xtal_prev = pins_s[PIN_XTAL];
    d.sclk_prev = pins_s[PIN_SCLK];
    d.xtal_out  = ~pins_s[PIN_XTAL];
    d.exc_a     = ~pins_s[PIN_ROUTE];
    d.exc_b     = pins_s[PIN_ROUTE];

    // bus slave: one wait state, unmapped reads zero, writes dropped except to ADR_AIN
    if (wb_cyc && wb_stb && !q.ack) begin
      d.ack   = 1'b1;
      d.rdata = reg_read(q, wb_adr, pins_s);
      if (wb_we && wb_adr == ADR_AIN) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel[i] && i * 8 < WORD_P) begin
            d.ain[i*8 +: 8] = wb_dat_w[i*8 +: 8];
          end
        end
      end
    end

    if (q.state != S_OFF) begin
      d.sclk_oe_n = mode_s;
    end
    if ((q.state == S_READY || q.state == S_SHIFT || q.state == S_TAIL)
        && !mode_s) begin
      d.div_cnt = (q.div_cnt == DIV_MAX) ? '0 : q.div_cnt + 1'b1;
      if (m_tog) begin
        d.sclk = ~q.sclk;
      end
    end else if (q.state == S_TAIL) begin
      d.div_cnt = (q.div_cnt == DIV_MAX) ? '0 : q.div_cnt + 1'b1;
    end

    case (q.state)
      S_OFF: begin
        d.sclk      = 1'b1;
        d.dout      = 1'b1;
        d.sclk_oe_n = 1'b1;
        d.dout_oe_n = 1'b1;
        if (!cs_s) begin
          d.state     = S_LOCK;
          d.lock_cnt  = '0;
          d.dout_oe_n = 1'b0;
          d.sclk_oe_n = mode_s;
        end
      end
      S_LOCK: begin
        if (xtal_tick) begin
          d.lock_cnt = q.lock_cnt + 1'b1;
          if (q.lock_cnt == LW'(LOCK_P - 1)) begin
            d.state = S_CONV;
          end
        end
      end
      S_CONV: begin
        d.dout = 1'b1;
        d.sclk = 1'b1;
        if (conv_done) begin
          d.state = S_UPD;
        end
      end
      S_UPD: begin
        d.shreg   = conv_code;
        d.result  = conv_code;
        d.bit_cnt = '0;
        d.div_cnt = '0;
        d.sclk    = 1'b1;
        d.dout    = 1'b0;
        d.state   = S_READY;
      end
      S_READY: begin
        if (conv_done) begin
          d.dout  = 1'b1;
          d.sclk  = 1'b1;
          d.state = S_UPD;
        end else if (fall_ev) begin
          d.dout  = q.shreg[WORD_P-1];
          d.shreg = {q.shreg[WORD_P-2:0], 1'b0};
          d.state = S_SHIFT;
        end
      end
      S_SHIFT: begin
        // bit count survives idle gaps between groups
        if (fall_ev) begin
          d.dout  = q.shreg[WORD_P-1];
          d.shreg = {q.shreg[WORD_P-2:0], 1'b0};
        end else if (rise_ev) begin
          if (q.bit_cnt == LAST_BIT) begin
            d.state   = S_TAIL;
            d.div_cnt = '0;
            d.xfers   = q.xfers + 1'b1;
          end else begin
            d.bit_cnt = q.bit_cnt + 1'b1;
          end
        end
      end
      S_TAIL: begin
        // last bit held half a period past its sampling edge
        if (q.div_cnt == DIV_MAX) begin
          d.dout  = 1'b1;
          d.state = S_CONV;
        end
      end
      default: d.state = S_OFF;
    endcase

    if (cs_s) begin
      d.state     = S_OFF;
      d.sclk      = 1'b1;
      d.dout      = 1'b1;
      d.sclk_oe_n = 1'b1;
      d.dout_oe_n = 1'b1;
      d.shreg     = '0;
      d.result    = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q           <= '0;
      q.state     <= S_OFF;
      q.sclk      <= 1'b1;
      q.dout      <= 1'b1;
      q.sclk_oe_n <= 1'b1;
      q.dout_oe_n <= 1'b1;
      q.xtal_prev <= 1'b1;
      q.sclk_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_r         = q.rdata;
  assign wb_ack           = q.ack;
  assign sclk_out         = q.sclk;
  assign sclk_oe_n        = q.sclk_oe_n;
  assign dout_rdy         = q.dout;
  assign dout_oe_n        = q.dout_oe_n;
  assign crystal_out      = q.xtal_out;
  assign excitation_out_a = q.exc_a;
  assign excitation_out_b = q.exc_b;

  ////////////////////////////////////////////////////////////////////////
  // rising sclk edges seen in one transfer
  logic [BW:0] rise_cnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || q.state == S_CONV || q.state == S_UPD) begin
      rise_cnt <= '0;
    end else if (rise_ev && q.state == S_SHIFT) begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  mode_drive_a: assert property (
    q.state != S_OFF && $past(q.state) != S_OFF && !$past(cs_s)
    |-> sclk_oe_n == $past(mode_s))
    else $error("sclk drive does not follow mode");
  edge_count_a: assert property (
    q.state == S_TAIL && $past(q.state) == S_SHIFT
    |-> rise_cnt == (BW+1)'(WORD_P))
    else $error("transfer did not see a full word of edges");
  rest_high_a: assert property (
    q.state == S_CONV || q.state == S_UPD |-> dout_rdy)
    else $error("data line low while no result is ready");
  ready_low_a: assert property (
    $past(q.state) == S_UPD && !$past(cs_s) |-> !dout_rdy)
    else $error("ready not signalled after update");
  change_fall_a: assert property (
    q.state == S_SHIFT && $changed(dout_rdy) |-> $past(fall_ev))
    else $error("data changed away from a falling edge");
  sclk_park_a: assert property (
    !mode_s && q.state == S_CONV |-> sclk_out)
    else $error("self-clocked sclk not parked high");
  tail_end_a: assert property (
    q.state == S_TAIL && !cs_s |-> ##[1:TAIL_MAX] q.state == S_CONV
    || q.state == S_OFF)
    else $error("line not returned high after the word");
  back_to_back_a: assert property (
    q.state == S_CONV && conv_done && !cs_s |=> q.state == S_UPD)
    else $error("finished conversion not taken");
  abort_a: assert property (
    cs_s |=> dout_oe_n && sclk_oe_n && q.result == '0)
    else $error("deselect did not float pins and drop result");
  update_high_a: assert property (
    q.state == S_READY && conv_done && !cs_s |=> dout_rdy)
    else $error("line low while word is replaced");
  msb_first_a: assert property (
    q.state == S_READY && fall_ev && !conv_done && !cs_s
    |=> dout_rdy == $past(q.shreg[WORD_P-1]))
    else $error("first bit is not the top bit");

  master_xfer_c: cover property (
    !mode_s && q.state == S_TAIL ##1 q.state == S_TAIL);
  slave_xfer_c: cover property (
    mode_s && q.state == S_TAIL ##1 q.state == S_TAIL);
  abort_shift_c: cover property (q.state == S_SHIFT && cs_s);
  update_ready_c: cover property (q.state == S_READY && conv_done);
endmodule

/* File: sdr_reader.sv */
`timescale 1ns/1ps
module sdr_reader (
  input  wire logic sclk_w,
  input  wire logic dout_w,
  output logic      sclk_drv
);
  logic [23:0] word;
  int          bits;

  initial sclk_drv = 1'b1; // parked high between transfers

  // sample on the rising edge, first bit ends up on top
  always @(posedge sclk_w) begin
    word = {word[22:0], dout_w};
    bits = bits + 1;
  end

  task clear();
    word = '0;
    bits = 0;
  endtask

  // reader makes the clock, one burst of n pulses
  task pulses(input int n);
    #13;
    repeat (n) begin
      sclk_drv = 1'b0;
      #160;
      sclk_drv = 1'b1;
      #160;
    end
  endtask
endmodule

/* File: sdr_top_tb.sv */
`timescale 1ns/1ps
module sdr_top_tb;
  import sdr_pkg::*;
  localparam int HALF = 4;
  logic        clk_sys, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        cs_n, mode_sel, range_sel, route_sel, sclk_out;
  logic        sclk_oe_n, dout_rdy, dout_oe_n, crystal_in, crystal_out;
  logic        exc_a, exc_b, sclk_drv, dout_last;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [4:0]  xtal_cnt;
  int          mismatches, comparisons;
  wire logic   sclk_w = sclk_oe_n ? sclk_drv : sclk_out;
  wire logic   dout_w = dout_oe_n ? ~dout_last : dout_rdy;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // released data line shows the inverse of its last level
  always @(posedge clk_sys) if (!dout_oe_n) dout_last <= dout_rdy;
  always @(posedge clk_sys) begin
    xtal_cnt <= (xtal_cnt == 5'd24) ? 5'd0 : xtal_cnt + 5'd1;
    if (xtal_cnt == 5'd24) crystal_in <= ~crystal_in;
  end

  sdr_top #(.CONV_P(8), .LOCK_P(2), .SCLK_HALF_P(HALF)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cs_n(cs_n), .mode_sel(mode_sel),
    .range_sel(range_sel), .excitation_route_select(route_sel),
    .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .dout_rdy(dout_rdy), .dout_oe_n(dout_oe_n), .crystal_in(crystal_in),
    .crystal_out(crystal_out), .excitation_out_a(exc_a),
    .excitation_out_b(exc_b));
  sdr_reader rdr (.sclk_w(sclk_w), .dout_w(dout_w), .sclk_drv(sclk_drv));

  ////////////////////////////////////////////////////////////////////////////
  task conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task timeout(input string what);
    mismatches++;
    $display("ERROR %0t %s timed out", $time, what);
    conclude();
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= 4'hf;
    wb_dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t bus answer missing", $time);
      conclude();
    end
  endtask

  task wait_ready(input int lim);
    int n;
    n = 0;
    while ((dout_oe_n !== 1'b0 || dout_w !== 1'b0) && n < lim) begin
      if (!sclk_oe_n && sclk_out !== 1'b1) begin
        mismatches++;
        $display("ERROR %0t clock moved before result", $time);
      end
      @(posedge clk_sys);
      n++;
    end
    if (dout_oe_n !== 1'b0 || dout_w !== 1'b0) begin
      mismatches++;
      $display("ERROR %0t ready never seen", $time);
      conclude();
    end
  endtask

  // waits until a waiting result is withdrawn from the line
  task wait_gone(input int lim);
    int n;
    n = 0;
    while (dout_oe_n === 1'b0 && dout_w === 1'b0 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (dout_oe_n === 1'b0 && dout_w === 1'b0) timeout("ready release");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_pins();
    int n;
    route_sel <= 1'b0;
    tick(6);
    chk({exc_a, exc_b}, 2'b10, "route a");
    route_sel <= 1'b1;
    tick(6);
    chk({exc_a, exc_b}, 2'b01, "route b");
    wb(1'b0, ADR_STATUS, '0);
    chk(rd[ST_ROUTE], 1'b1, "status route");
    chk(rd[ST_SEL], 1'b0, "status select");
    wb(1'b0, 4'h2, '0);
    chk(rd, '0, "unmapped read");
    for (n = 0; n < 30 && xtal_cnt !== 5'd12; n++) @(posedge clk_sys);
    if (xtal_cnt !== 5'd12) timeout("crystal phase");
    chk(crystal_out, !crystal_in, "crystal out");
    $display("test pins done");
  endtask

  task master_case(input logic [23:0] ain, input logic rng,
                   input logic [23:0] exp);
    int n;
    range_sel <= rng;
    wb(1'b1, ADR_AIN, {8'h00, ain});
    repeat (2) begin
      wait_ready(2000);
      rdr.clear();
      for (n = 0; n < 400 && rdr.bits < 24; n++) @(posedge clk_sys);
      if (rdr.bits < 24) timeout("master word");
      tick(HALF + 2);
    end
    chk(rdr.word, exp, "master word");
    chk(rdr.bits, 24, "master edges");
    chk(dout_rdy, 1'b1, "line high after word");
    wb(1'b0, ADR_RESULT, '0);
    chk(rd, {8'h00, exp}, "result word");
    wait_ready(2000);
    chk(rdr.bits, 24, "clock parked");
    $display("test master %h done", ain);
  endtask

  task t_deselect();
    wait_ready(2000);
    tick(40);
    cs_n <= 1'b1;
    tick(5);
    chk({sclk_oe_n, dout_oe_n}, 2'b11, "pins floated");
    wb(1'b1, ADR_RESULT, 32'hffffffff);
    wb(1'b0, ADR_RESULT, '0);
    chk(rd, '0, "result dropped");
    cs_n <= 1'b0;
    wait_ready(2000);
    chk(sclk_oe_n, 1'b0, "device drives clock");
    $display("test deselect done");
  endtask

  task t_slave();
    int g;
    int i;
    logic [31:0] base;
    cs_n     <= 1'b1;
    mode_sel <= 1'b1;
    range_sel <= 1'b1;
    tick(5);
    cs_n <= 1'b0;
    wb(1'b1, ADR_AIN, 32'h00123456);
    chk(sclk_oe_n, 1'b1, "reader drives clock");
    wb(1'b0, ADR_XFERS, '0);
    base = rd;
    for (g = 8; g <= 24; g += 16) begin
      wait_ready(2000);
      if (g == 8) begin
        // unread word is replaced by the next one, line bounces high
        wait_gone(600);
        wait_ready(20);
      end
      rdr.clear();
      for (i = 0; i < 24 / g; i++) begin
        rdr.pulses(g);
        tick(20);
      end
      chk(rdr.word, 24'h923456, "slave word");
      chk(rdr.bits, 24, "slave bits");
      chk(dout_rdy, 1'b1, "line high after read");
      wb(1'b0, ADR_XFERS, '0);
      base = base + 32'h1;
      chk(rd, base, "transfer count");
    end
    $display("test slave done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n      = 1'b0;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = '0;
    wb_sel     = 4'h0;
    wb_dat_w   = '0;
    cs_n       = 1'b1;
    mode_sel   = 1'b0;
    range_sel  = 1'b1;
    route_sel  = 1'b0;
    crystal_in = 1'b0;
    xtal_cnt   = '0;
    dout_last  = 1'b0;
    tick(10);
    chk({sclk_oe_n, dout_oe_n, dout_rdy, sclk_out}, 4'hf, "reset pins");
    rst_n <= 1'b1;
    t_pins();
    cs_n <= 1'b0;
    master_case(24'h000000, 1'b1, 24'h800000);
    master_case(24'h7fffff, 1'b1, 24'hffffff);
    master_case(24'h800000, 1'b1, 24'h000000);
    master_case(24'h000010, 1'b0, 24'h800100);
    master_case(24'h100000, 1'b0, 24'hffffff);
    t_deselect();
    t_slave();
    conclude();
  end
endmodule
